// *** pkg/vsq_params.svh ***
`ifndef VSQ_PARAMS_SVH
`define VSQ_PARAMS_SVH
// register offsets (command codes)
`define VSQ_OFS_PHASE_CFG    8'h03
`define VSQ_OFS_VR_CFG_A     8'hd2
`define VSQ_OFS_VR_CFG_B     8'hd3
`define VSQ_OFS_DELAY_SEL    8'hd4
`define VSQ_OFS_OC_TRIM      8'he2
// field positions
`define VSQ_LATCH_EN_BIT     1
`define VSQ_PSI_CODE_HI      7
`define VSQ_PSI_CODE_LO      6
`define VSQ_PHASE_CNT_HI     2
`define VSQ_PHASE_CNT_LO     0
// reset values
`define VSQ_RST_DELAY_SEL    8'h03
`define VSQ_RST_OC_TRIM      8'h10
`define VSQ_RST_VR_CFG       8'h02
`define VSQ_RST_PHASE_CFG    8'h07
// timing
`define VSQ_CLK_HZ           10000000
`define VSQ_STEP_US          500
`define VSQ_STEP_CYC         ((`VSQ_STEP_US * (`VSQ_CLK_HZ / 1000000)))
`define VSQ_BLANK_US         100
`define VSQ_BLANK_CYC        ((`VSQ_BLANK_US * (`VSQ_CLK_HZ / 1000000)))
`define VSQ_LATCH_MULT       4
`endif

// *** pkg/vsq_pkg.sv ***
package vsq_pkg;
    // startup and protection sequence states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_TD1,
        ST_SOFTSTART,
        ST_TD3,
        ST_TD5,
        ST_RUN,
        ST_LATCHED
    } vsq_state_type;
endpackage

// *** hw/vsq_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vsq_params.svh"
module vsq_ctrl
    import vsq_pkg::*;
#(
    parameter int STEP_CYC  = `VSQ_STEP_CYC,   // 0.5 ms in clocks
    parameter int BLANK_CYC = `VSQ_BLANK_CYC,  // 100 us in clocks
    parameter int CNT_W     = 18               // holds 4 x 4 ms
)(
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    input  wire logic       i_enable,          // enable pin, above threshold
    input  wire logic       i_supply_ok,       // supply above lockout
    // register port, byte wide, documented command codes
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    // analog comparator results
    input  wire logic       i_softstart_done,  // soft-start at target
    input  wire logic       i_vout_in_window,  // inside power-good window
    input  wire logic       i_vout_below_200mv,
    input  wire logic       i_current_limit,   // limit reached
    input  wire logic       i_no_cpu_code,     // voltage code says no cpu
    input  wire logic       i_voltage_code_changed, // one-cycle strobe
    input  wire logic       i_load_release,
    input  wire logic       i_load_step,
    input  wire logic       i_power_state_in,  // low = low-power state
    // window limits passed to the analog comparator
    input  wire logic [7:0] i_pg_high_limit,
    input  wire logic [7:0] i_pg_low_limit,
    output logic      [7:0] o_pg_high_limit,
    output logic      [7:0] o_pg_low_limit,
    // outputs
    output logic            o_output_in_range_out,
    output logic            o_low_power_phase_disable_n,
    output logic            o_switching_en,
    output logic            o_latched_off,
    output logic            o_secondary_limit_sel,
    output logic      [4:0] o_limit_trim,
    output logic      [2:0] o_limit_divisor,
    output logic      [7:0] o_phase_enable,
    output logic            o_load_release_flag_out,
    output logic            o_all_phase_boost
);
    // overview of the control flow:
    // - enable and supply-ok together gate the sequence and switching; either one
    //   low drops the sequence back to off and clears both timers
    // - off lasts one clock, then the first timed delay runs
    // - soft-start waits on the analog ramp comparator, untimed
    // - the third and fifth delays use the same interval length
    // - run is the only state that may count towards latchoff
    // - latched is left only through reset, enable or supply
    // one shared counter times the three startup delays; the
    // latchoff counter is separate so that it can be abandoned
    // without disturbing the interval that was captured for it
    // all pin-side outputs are registered, so every output lags
    // the state by one clock; the checker allows for that lag
    // the host-side inputs are taken as already synchronous

    //************************************************************
    // registers
    //************************************************************
    logic [7:0]    phase_cfg_reg;   // 7:6 low-power code, 2:0 count-1
    logic [7:0]    vr_cfg_a_reg;
    logic [7:0]    vr_cfg_b_reg;
    logic [7:0]    delay_sel_reg;
    logic [7:0]    oc_trim_reg;
    vsq_state_type state_reg;
    vsq_state_type state_next;
    logic [CNT_W-1:0] tmr_reg;      // shared delay counter
    logic [CNT_W-1:0] tmr_next;
    logic [CNT_W-1:0] ivl_reg;      // interval latched at start
    logic [CNT_W-1:0] lat_reg;      // latchoff counter
    logic [CNT_W-1:0] lat_next;
    logic [15:0]      blank_reg;    // power-good blanking counter

    //************************************************************
    // decode
    //************************************************************
    // interval in clocks for a delay code
    function automatic logic [CNT_W-1:0] interval_of(input logic [2:0] code);
        interval_of = CNT_W'(({29'h0, code} + 32'h1) * STEP_CYC);
    endfunction

    wire logic       run_ok     = i_enable & i_supply_ok;
    wire logic [2:0] delay_code = delay_sel_reg[2:0];
    wire logic [CNT_W-1:0] ivl_now = interval_of(delay_code);
    wire logic [CNT_W-1:0] lat_len = CNT_W'(ivl_reg * `VSQ_LATCH_MULT);
    // latchoff armed unless bit cleared in both config registers
    wire logic latch_armed = vr_cfg_a_reg[`VSQ_LATCH_EN_BIT]
                           | vr_cfg_b_reg[`VSQ_LATCH_EN_BIT];
    wire logic tmr_done  = (tmr_reg >= ivl_reg - CNT_W'(1));
    wire logic lat_done  = (lat_reg >= lat_len - CNT_W'(1));
    wire logic blanking  = (blank_reg != 16'h0);
    wire logic [2:0] phase_cnt  = phase_cfg_reg[`VSQ_PHASE_CNT_HI:`VSQ_PHASE_CNT_LO];
    wire logic [1:0] lp_code    = phase_cfg_reg[`VSQ_PSI_CODE_HI:`VSQ_PSI_CODE_LO];
    wire logic       low_power  = ~i_power_state_in;
    wire logic       timing     = (state_reg == ST_TD1) | (state_reg == ST_TD3)
                                | (state_reg == ST_TD5);
    wire logic       reg_hit    = (i_reg_addr == `VSQ_OFS_PHASE_CFG)
                                | (i_reg_addr == `VSQ_OFS_VR_CFG_A)
                                | (i_reg_addr == `VSQ_OFS_VR_CFG_B)
                                | (i_reg_addr == `VSQ_OFS_DELAY_SEL)
                                | (i_reg_addr == `VSQ_OFS_OC_TRIM);

    //************************************************************
    // low-power phase map
    //************************************************************
    // the phase count field holds count minus one, so 3'h7 is
    // eight phases and 3'h0 is a single phase
    // only eight and six phases keep more than phase 1 in the
    // low-power state; every other count sheds down to phase 1
    // the divisor scales the current limit to the phases left,
    // so that the per-phase limit stays roughly where it was
    // six-phase code 11 is ambiguous in the tables; it is taken
    // as the same set as code 10, which is the safer of the two
    // because it never leaves fewer phases than the divisor assumes
    logic [7:0] lp_mask;   // phases kept in low-power state
    logic [2:0] lp_div;    // limit divisor in low-power state
    always_comb
    begin
        lp_mask = 8'h01;
        lp_div  = 3'h2;
        unique case (phase_cnt)
            3'h7:   // eight phases
            begin
                lp_mask = (lp_code == 2'h0) ? 8'h01 :
                          (lp_code == 2'h1) ? 8'h11 : 8'h55;
                lp_div  = lp_code[1] ? 3'h2 : 3'h4;
            end
            3'h5:   // six phases; code 11 taken as phases 1,3,5
            begin
                lp_mask = (lp_code == 2'h0) ? 8'h01 :
                          (lp_code == 2'h1) ? 8'h09 : 8'h15;
                lp_div  = (lp_code == 2'h0) ? 3'h4 :
                          (lp_code == 2'h1) ? 3'h3 : 3'h2;
            end
            3'h6, 3'h4, 3'h3:  // seven, five, four phases
                lp_div = (lp_code == 2'h0) ? 3'h4 : 3'h2;
            3'h2:   // three phases
                lp_div = (lp_code == 2'h0) ? 3'h3 : 3'h2;
            3'h1:   // two phases
                lp_div = 3'h2;
            3'h0:   // single phase
                lp_div = 3'h1;
        endcase
    end
    // all configured phases mask
    // count 3'h7 gives 8'hff, count 3'h0 gives phase 1 alone
    wire logic [7:0] full_mask = 8'hff >> (3'h7 - phase_cnt);

    //************************************************************
    // sequence
    //************************************************************
    // sequence notes:
    // - the delay counter only runs in the three timed states and
    //   is zero everywhere else, so each timed state starts clean
    // - a timed state ends on the clock where the counter reaches
    //   interval minus one, giving exactly interval clocks in it
    // - the latchoff counter advances only while the limit is seen
    //   in run with latchoff armed; one clock without the limit
    //   drops it to zero, which is how an overcurrent is forgiven
    // - a limit during startup is ignored on purpose: the delays
    //   must complete before latchoff may even begin counting
    // - latched holds until the enable or supply path clears it
    // next state; current limit never interrupts TD1..TD5
    always_comb
    begin
        state_next = state_reg;
        tmr_next   = timing ? tmr_reg + CNT_W'(1) : '0;
        lat_next   = '0;
        unique case (state_reg)
            ST_OFF:       state_next = ST_TD1;
            ST_TD1:       if (tmr_done) state_next = ST_SOFTSTART;
            ST_SOFTSTART: if (i_softstart_done) state_next = ST_TD3;
            ST_TD3:       if (tmr_done) state_next = ST_TD5;
            ST_TD5:       if (tmr_done) state_next = ST_RUN;
            ST_RUN:
            begin
                // limit after TD5 runs latchoff; clearing abandons it
                if (i_current_limit & latch_armed)
                begin
                    lat_next = lat_reg + CNT_W'(1);
                    if (lat_done) state_next = ST_LATCHED;
                end
            end
            ST_LATCHED:   state_next = ST_LATCHED;
        endcase
        if (timing & tmr_done) tmr_next = '0;
    end

    // state and timers; cleared when disabled or under lockout
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg <= ST_OFF;
            tmr_reg   <= '0;
            lat_reg   <= '0;
        end
        else if (!run_ok)
        begin
            state_reg <= ST_OFF;
            tmr_reg   <= '0;
            lat_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            tmr_reg   <= tmr_next;
            lat_reg   <= lat_next;
        end
    end

    // interval reloaded outside the timed states and at each delay's end; held during a delay and a latchoff count
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            ivl_reg <= interval_of(3'(`VSQ_RST_DELAY_SEL));
        else if (!timing & (state_reg != ST_RUN || lat_reg == '0))
            ivl_reg <= ivl_now;
        else if (timing & tmr_done)
            ivl_reg <= ivl_now;
    end

    // the blanking counter is reloaded by every strobe, not only
    // the first, so a staircase of code steps keeps power-good
    // masked until the last step has settled
    // limitation: the counter is 16 bits, so BLANK_CYC must fit
    // blanking window, restarted by every code change
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            blank_reg <= '0;
        else if (i_voltage_code_changed)
            blank_reg <= 16'(BLANK_CYC);
        else if (blanking)
            blank_reg <= blank_reg - 16'h1;
    end

    //************************************************************
    // register writes
    //************************************************************
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            phase_cfg_reg <= `VSQ_RST_PHASE_CFG;
            vr_cfg_a_reg  <= `VSQ_RST_VR_CFG;
            vr_cfg_b_reg  <= `VSQ_RST_VR_CFG;
            delay_sel_reg <= `VSQ_RST_DELAY_SEL;
            oc_trim_reg   <= `VSQ_RST_OC_TRIM;
        end
        else if (i_reg_wr)
        begin
            unique case (i_reg_addr)
                `VSQ_OFS_PHASE_CFG: phase_cfg_reg <= i_reg_wdata;
                `VSQ_OFS_VR_CFG_A:  vr_cfg_a_reg  <= i_reg_wdata;
                `VSQ_OFS_VR_CFG_B:  vr_cfg_b_reg  <= i_reg_wdata;
                `VSQ_OFS_DELAY_SEL: delay_sel_reg <= i_reg_wdata;
                `VSQ_OFS_OC_TRIM:   oc_trim_reg   <= i_reg_wdata;
                default:            ;  // unmapped: ignored
            endcase
        end
    end

    // reads are registered one clock behind the address, which
    // keeps the read path off the output pins' timing
    // the trim register only holds five meaningful bits; the
    // upper three read back as zero whatever was written
    // unmapped addresses read as zero and writes there are lost
    // read mux; unmapped reads as zero
    wire logic [7:0] rdata_next =
        (i_reg_addr == `VSQ_OFS_PHASE_CFG) ? phase_cfg_reg :
        (i_reg_addr == `VSQ_OFS_VR_CFG_A)  ? vr_cfg_a_reg  :
        (i_reg_addr == `VSQ_OFS_VR_CFG_B)  ? vr_cfg_b_reg  :
        (i_reg_addr == `VSQ_OFS_DELAY_SEL) ? delay_sel_reg :
        (i_reg_addr == `VSQ_OFS_OC_TRIM)   ? {3'h0, oc_trim_reg[4:0]} :
        8'h00;

    //************************************************************
    // outputs, all registered
    //************************************************************
    // power-good needs run, the window, a real cpu code and no
    // blanking; it is low from the first off clock onwards
    // switching starts at soft-start, so the delay before it
    // keeps the drivers quiet while references settle
    // the secondary limit only applies before run, while the
    // output is still near zero volts
    // load step overrides the low-power shedding for its length
    wire logic running  = (state_reg == ST_RUN);
    wire logic pg_next  = running & run_ok & i_vout_in_window
                        & ~i_no_cpu_code & ~blanking;
    wire logic sw_next  = run_ok & (state_reg != ST_OFF)
                        & (state_reg != ST_LATCHED) & (state_reg != ST_TD1);
    // load step overrides low-power shedding
    wire logic [7:0] ph_next = ~sw_next ? 8'h00 :
                               (low_power & ~i_load_step) ? lp_mask : full_mask;

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_reg_rdata                 <= 8'h00;
            o_pg_high_limit             <= 8'h00;
            o_pg_low_limit              <= 8'h00;
            o_output_in_range_out       <= 1'b0;
            o_low_power_phase_disable_n <= 1'b0;
            o_switching_en              <= 1'b0;
            o_latched_off               <= 1'b0;
            o_secondary_limit_sel       <= 1'b0;
            o_limit_trim                <= 5'h10;
            o_limit_divisor             <= 3'h1;
            o_phase_enable              <= 8'h00;
            o_load_release_flag_out     <= 1'b0;
            o_all_phase_boost           <= 1'b0;
        end
        else
        begin
            o_reg_rdata                 <= reg_hit ? rdata_next : 8'h00;
            o_pg_high_limit             <= i_pg_high_limit;
            o_pg_low_limit              <= i_pg_low_limit;
            o_output_in_range_out       <= pg_next;
            o_low_power_phase_disable_n <= sw_next & ~low_power;
            o_switching_en              <= sw_next;
            o_latched_off               <= (state_reg == ST_LATCHED);
            o_secondary_limit_sel       <= sw_next & ~running & i_vout_below_200mv;
            o_limit_trim                <= oc_trim_reg[4:0];
            o_limit_divisor             <= low_power ? lp_div : 3'h1;
            o_phase_enable              <= ph_next;
            o_load_release_flag_out     <= sw_next & i_load_release;
            o_all_phase_boost           <= sw_next & i_load_step;
        end
    end
endmodule // vsq_ctrl
`default_nettype wire

// *** tb/vsq_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ports grouped several to a line to keep the checker compact
module vsq_ctrl_assertions #(
    parameter int STEP_CYC = 10  // shortest delay step in clocks
)(
    input wire logic       i_mclk, i_reset_n, i_enable, i_current_limit,
    input wire logic       i_no_cpu_code, i_voltage_code_changed, i_load_release,
    input wire logic       i_power_state_in, o_output_in_range_out, o_switching_en,
    input wire logic       o_low_power_phase_disable_n, o_latched_off,
    input wire logic       o_load_release_flag_out,
    input wire logic [2:0] o_limit_divisor
);
    // ***************************************
    // helper: run length of the limit input
    // ***************************************
    logic [15:0] lim_run_reg;  // cycles with limit high in a row
    // cleared on limit drop or enable low, two of the events that end a latchoff count
    always_ff @(posedge i_mclk or negedge i_reset_n)
        if (!i_reset_n)
            lim_run_reg <= 16'h0000;
        else if (!i_current_limit || !i_enable)
            lim_run_reg <= 16'h0000;
        else if (lim_run_reg != 16'hffff)
            lim_run_reg <= lim_run_reg + 16'h0001;
    // ***************************************
    // properties
    // ***************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    a_pg_enable_low: assert property (!i_enable [*3] |-> !o_output_in_range_out)
        else $error("power good high with enable low");
    a_pg_no_cpu: assert property (i_no_cpu_code [*3] |-> !o_output_in_range_out)
        else $error("power good high with no-cpu code");
    a_pg_blank_hold: assert property (i_voltage_code_changed |=> ##1 !o_output_in_range_out [*4])
        else $error("power good not blanked after code change");
    a_pg_needs_switch: assert property (o_output_in_range_out |-> o_switching_en)
        else $error("power good while not switching");
    a_low_power_odn: assert property (!i_power_state_in [*2] |-> !o_low_power_phase_disable_n)
        else $error("phase disable not low in low power");
    a_latch_stops_run: assert property (o_latched_off |-> !o_switching_en && !o_output_in_range_out)
        else $error("switching while latched off");
    a_latch_after_delay: assert property ($rose(o_latched_off) |-> lim_run_reg >= 16'(4 * STEP_CYC))
        else $error("latchoff before four intervals of limit");
    a_enable_stops_all: assert property (!i_enable [*3] |-> !o_switching_en && !o_latched_off)
        else $error("enable low left sequence running");
    a_release_flag: assert property (i_load_release ##1 (i_load_release && o_switching_en) |-> o_load_release_flag_out)
        else $error("load release flag missing");
    a_divisor_legal: assert property (o_limit_divisor inside {3'h1, 3'h2, 3'h3, 3'h4})
        else $error("illegal limit divisor");
endmodule // vsq_ctrl_assertions
bind vsq_ctrl vsq_ctrl_assertions #(.STEP_CYC(STEP_CYC)) u_chk (.*);
`default_nettype wire

// *** tb/vsq_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// output stage model: ramps while switching, collapses when stopped
module vsq_partner #(
    parameter int SS_CYC = 12  // soft-start ramp length in clocks
)(
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    input  wire logic i_switching_en,
    output logic      o_softstart_done,
    output logic      o_vout_in_window,
    output logic      o_vout_below_200mv
);
    logic [7:0] ramp_reg;  // clocks since switching began
    // saturating ramp so a long run never wraps back to zero volts
    always_ff @(posedge i_mclk or negedge i_reset_n)
        if (!i_reset_n)
            ramp_reg <= 8'h00;
        else if (!i_switching_en)
            ramp_reg <= 8'h00;
        else if (ramp_reg != 8'hff)
            ramp_reg <= ramp_reg + 8'h01;
    assign o_vout_below_200mv = (ramp_reg < 8'h04);
    assign o_softstart_done   = (ramp_reg >= 8'(SS_CYC));
    assign o_vout_in_window   = o_softstart_done;
endmodule // vsq_partner
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import vsq_pkg::*;
    // ***************************************
    // stimulus and observation
    // ***************************************
    logic i_mclk = 1'b0, i_reset_n = 1'b0, i_enable = 1'b0, i_reg_wr = 1'b0;
    logic i_current_limit = 1'b0, i_no_cpu_code = 1'b0, i_voltage_code_changed = 1'b0;
    logic i_load_release = 1'b0, i_load_step = 1'b0, i_power_state_in = 1'b1, supply_ok = 1'b1;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_pg_high_limit = 8'h00;
    logic [7:0] i_pg_low_limit = 8'h00;
    logic [7:0] o_reg_rdata, o_pg_high_limit, o_pg_low_limit, o_phase_enable;
    logic [4:0] o_limit_trim;
    logic [2:0] o_limit_divisor;
    logic ss_done, in_win, below, pg, odn_n, sw, latched, sec, rel, boost, seen_sec;
    int n_fail = 0, tests_run = 0, cyc_cnt = 0, t_def, t_one, k;
    // cfg, expected phase mask, expected divisor in low power
    logic [23:0] lp_tab [16] = '{24'h07_01_04, 24'h47_11_04, 24'h87_55_02, 24'hc7_55_02,
        24'h06_01_04, 24'h86_01_02, 24'h05_01_04, 24'h45_09_03, 24'h85_15_02, 24'hc5_15_02,
        24'h44_01_02, 24'h03_01_04, 24'h02_01_03, 24'h42_01_02, 24'h01_01_02, 24'h00_01_01};
    always #50 i_mclk = ~i_mclk;
    vsq_ctrl #(.STEP_CYC(10), .BLANK_CYC(5)) DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_enable(i_enable), .i_supply_ok(supply_ok), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_softstart_done(ss_done),
        .i_vout_in_window(in_win), .i_vout_below_200mv(below), .i_current_limit(i_current_limit),
        .i_no_cpu_code(i_no_cpu_code), .i_voltage_code_changed(i_voltage_code_changed),
        .i_load_release(i_load_release), .i_load_step(i_load_step),
        .i_power_state_in(i_power_state_in), .i_pg_high_limit(i_pg_high_limit),
        .i_pg_low_limit(i_pg_low_limit), .o_pg_high_limit(o_pg_high_limit),
        .o_pg_low_limit(o_pg_low_limit),
        .o_output_in_range_out(pg), .o_low_power_phase_disable_n(odn_n), .o_switching_en(sw),
        .o_latched_off(latched), .o_secondary_limit_sel(sec), .o_limit_trim(o_limit_trim),
        .o_limit_divisor(o_limit_divisor), .o_phase_enable(o_phase_enable),
        .o_load_release_flag_out(rel), .o_all_phase_boost(boost));
    vsq_partner #(.SS_CYC(12)) u_stage (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_switching_en(sw), .o_softstart_done(ss_done), .o_vout_in_window(in_win),
        .o_vout_below_200mv(below));
    // ***************************************
    // tasks
    // ***************************************
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_mclk);
        i_reg_wr = 1'b0;
    endtask
    // address set, registered data looked at one edge later
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_mclk);
        i_reg_addr = a;
        @(negedge i_mclk);
        chk(o_reg_rdata, exp);
    endtask
    // enable pulse low, then clocks until power good rises
    task automatic start_up(output int cyc);
        i_enable = 1'b0;
        repeat (3) @(negedge i_mclk);
        i_enable = 1'b1;
        cyc = 0;
        while (pg !== 1'b1 && cyc < 2000)
        begin
            @(negedge i_mclk);
            cyc++;
            if (sec === 1'b1) seen_sec = 1'b1;
        end
        // a start that never reaches power good is a failure
        if (pg !== 1'b1) n_fail++;
    endtask
    task automatic hold(input int n, input logic [7:0] exp_latched);
        repeat (n) @(negedge i_mclk);
        chk({7'h00, latched}, exp_latched);
    endtask
    // hang guard: all sequences finish well inside this
    always @(posedge i_mclk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 30000)
        begin
            n_fail++;
            stop_test();
        end
    end
    // ***************************************
    // main sequence
    // ***************************************
    initial
    begin
        seen_sec = 1'b0;
        repeat (3) @(negedge i_mclk);
        i_reset_n = 1'b1;
        rd_chk(8'h03, 8'h07);
        rd_chk(8'hd2, 8'h02);
        rd_chk(8'hd3, 8'h02);
        rd_chk(8'hd4, 8'h03);
        rd_chk(8'he2, 8'h10);
        rd_chk(8'h55, 8'h00);
        start_up(t_def);
        wr(8'hd4, 8'h07);
        start_up(t_one);
        chk(8'(t_one - t_def), 8'h78);
        wr(8'hd4, 8'h00);
        start_up(t_one);
        chk(8'(t_def - t_one), 8'h5a);
        chk({7'h00, seen_sec}, 8'h01);
        i_current_limit = 1'b1;
        hold(30, 8'h00);
        i_current_limit = 1'b0;
        hold(5, 8'h00);
        i_current_limit = 1'b1;
        hold(36, 8'h00);
        hold(10, 8'h01);
        start_up(t_def);
        chk(8'(t_def), 8'(t_one));
        hold(1, 8'h00);
        hold(46, 8'h01);
        i_current_limit = 1'b0;
        wr(8'hd2, 8'h00);
        wr(8'hd3, 8'h00);
        start_up(t_def);
        i_current_limit = 1'b1;
        hold(100, 8'h00);
        i_current_limit = 1'b0;
        i_power_state_in = 1'b0;
        for (k = 0; k < 16; k++)
        begin
            wr(8'h03, lp_tab[k][23:16]);
            repeat (2) @(negedge i_mclk);
            chk(o_phase_enable, lp_tab[k][15:8]);
            chk({5'h00, o_limit_divisor}, lp_tab[k][7:0]);
        end
        chk({7'h00, odn_n}, 8'h00);
        i_load_step = 1'b1;
        i_load_release = 1'b1;
        repeat (3) @(negedge i_mclk);
        chk({6'h00, boost, rel}, 8'h03);
        i_load_step = 1'b0;
        i_load_release = 1'b0;
        i_power_state_in = 1'b1;
        wr(8'h03, 8'h07);
        repeat (2) @(negedge i_mclk);
        chk({o_phase_enable[6:0], odn_n}, 8'hff);
        wr(8'he2, 8'hff);
        rd_chk(8'he2, 8'h1f);
        chk({3'h0, o_limit_trim}, 8'h1f);
        i_pg_high_limit = 8'ha5;
        i_pg_low_limit = 8'h5a;
        i_voltage_code_changed = 1'b1;
        @(negedge i_mclk);
        i_voltage_code_changed = 1'b0;
        repeat (2) @(negedge i_mclk);
        chk({7'h00, pg}, 8'h00);
        chk(o_pg_high_limit, 8'ha5);
        chk(o_pg_low_limit, 8'h5a);
        // second step inside the window must restart blanking
        i_voltage_code_changed = 1'b1;
        @(negedge i_mclk);
        i_voltage_code_changed = 1'b0;
        repeat (3) @(negedge i_mclk);
        chk({7'h00, pg}, 8'h00);
        repeat (10) @(negedge i_mclk);
        chk({7'h00, pg}, 8'h01);
        i_no_cpu_code = 1'b1;
        repeat (3) @(negedge i_mclk);
        chk({7'h00, pg}, 8'h00);
        i_no_cpu_code = 1'b0;
        supply_ok = 1'b0;
        repeat (3) @(negedge i_mclk);
        chk({6'h00, sw, pg}, 8'h00);
        supply_ok = 1'b1;
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
